// ### hw/orrm_matrix.sv
// Stage timing, blocking and output relay routing matrix
`timescale 1ns/100ps
`default_nettype none
module orrm_matrix #(
    parameter int CUR_W = orrm_pkg::CUR_WIDTH,
    parameter int DLY_W = orrm_pkg::DLY_WIDTH
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          clkEn,
    input  wire logic [CUR_W-1:0]              neutralCurrent,
    input  wire logic [CUR_W-1:0]              lowStartLevel,
    input  wire logic [CUR_W-1:0]              highStartLevel,
    input  wire logic [DLY_W-1:0]              lowDelayCycles,
    input  wire logic [DLY_W-1:0]              highDelayCycles,
    input  wire logic [orrm_pkg::SW_COUNT-1:0] outputRoutingSwitches,
    input  wire logic                          blockLowEn,
    input  wire logic                          blockHighEn,
    input  wire logic                          externalBlockInput,
    input  wire logic                          internalFault,
    output logic                               relayA,
    output logic                               relayB,
    output logic                               relayC,
    output logic                               relayD,
    output logic                               relayF,
    output logic                               startTwoNormal,
    output logic                               startTwoActive,
    output logic                               alarmCoil,
    output logic                               alarmHealthyContact,
    output logic                               alarmFaultContact,
    output logic                               lowStart,
    output logic                               lowTrip,
    output logic                               highStart,
    output logic                               highTrip,
    output logic                               blockActive
);
    import orrm_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (CUR_W < 1 || DLY_W < 1) begin : g_chk
            $error("orrm_matrix: widths must be at least 1");
        end
    endgenerate

    // ************************************************************
    // Pin input synchronisation
    // ************************************************************
    logic blockSync;

    orrm_sync #(
        .WIDTH (1)
    ) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .asyncIn (externalBlockInput),
        .syncOut (blockSync)
    );

    // ************************************************************
    // Blocking path
    // ************************************************************
    logic                   blockRouted;
    logic [STAGE_COUNT-1:0] stageBlocked;

    // Switch cleared leaves the stages deaf to the block input
    assign blockRouted = blockSync
                       & outputRoutingSwitches[SW_BLOCK_ROUTE];
    assign stageBlocked[STAGE_LOW]  = blockRouted & blockLowEn;
    assign stageBlocked[STAGE_HIGH] = blockRouted & blockHighEn;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blockActive <= RELAY_RESET;
        end else if (clkEn) begin
            blockActive <= blockRouted;
        end
    end

    // ************************************************************
    // Definite time stages
    // ************************************************************
    logic [CUR_W-1:0]       startLevel [STAGE_COUNT];
    logic [DLY_W-1:0]       delayCycles[STAGE_COUNT];
    logic [STAGE_COUNT-1:0] stageStart;
    logic [STAGE_COUNT-1:0] stageTrip;

    assign startLevel[STAGE_LOW]   = lowStartLevel;
    assign startLevel[STAGE_HIGH]  = highStartLevel;
    assign delayCycles[STAGE_LOW]  = lowDelayCycles;
    assign delayCycles[STAGE_HIGH] = highDelayCycles;

    genvar s;
    generate
        for (s = 0; s < STAGE_COUNT; s++) begin : g_stage
            orrm_stage_t      state_q;
            orrm_stage_t      state_d;
            logic [DLY_W-1:0] count_q;
            logic             over;

            assign over = (neutralCurrent > startLevel[s])
                        & ~stageBlocked[s];

            always_comb begin
                state_d = state_q;
                case (state_q)
                    ORRM_IDLE: begin
                        if (over) begin
                            state_d = ORRM_STARTED;
                        end
                    end
                    ORRM_STARTED: begin
                        if (!over) begin
                            state_d = ORRM_IDLE;
                        end else if (count_q >= delayCycles[s]) begin
                            state_d = ORRM_TRIPPED;
                        end
                    end
                    ORRM_TRIPPED: begin
                        if (!over) begin
                            state_d = ORRM_IDLE;
                        end
                    end
                    default: begin
                        state_d = ORRM_IDLE;
                    end
                endcase
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    state_q <= ORRM_IDLE;
                end else if (clkEn) begin
                    state_q <= state_d;
                end
            end

            // Saturates so a long fault cannot wrap and drop the trip
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    count_q <= '0;
                end else if (clkEn) begin
                    if (state_d != ORRM_STARTED) begin
                        count_q <= '0;
                    end else if (count_q != {DLY_W{1'b1}}) begin
                        count_q <= count_q + 1'b1;
                    end
                end
            end

            // Block forces the stage idle, so both outputs drop
            assign stageStart[s] = (state_q != ORRM_IDLE) & over;
            assign stageTrip[s]  = (state_q == ORRM_TRIPPED) & over;
        end
    endgenerate

    // ************************************************************
    // Routing matrix
    // ************************************************************
    logic lsStart;
    logic hsStart;
    logic lsTrip;
    logic hsTrip;
    logic relayAD;
    logic relayBD;
    logic relayCD;
    logic relayDD;
    logic relayFD;

    assign lsStart = stageStart[STAGE_LOW];
    assign hsStart = stageStart[STAGE_HIGH];
    assign lsTrip  = stageTrip[STAGE_LOW];
    assign hsTrip  = stageTrip[STAGE_HIGH];

    // Fixed wiring has no switch term at all
    assign relayFD = lsStart;
    assign relayAD = lsTrip
                   | (hsTrip & outputRoutingSwitches[SW_HS_TRIP_A]);
    assign relayBD = hsTrip
                   | (lsTrip & outputRoutingSwitches[SW_LS_TRIP_B]);
    assign relayCD = (hsTrip & outputRoutingSwitches[SW_HS_TRIP_C])
                   | (lsTrip & outputRoutingSwitches[SW_LS_TRIP_C]);
    assign relayDD = (hsStart & outputRoutingSwitches[SW_HS_START_D])
                   | (lsStart & outputRoutingSwitches[SW_LS_START_D])
                   | (hsTrip  & outputRoutingSwitches[SW_HS_TRIP_D]);

    // ************************************************************
    // Relay drivers
    // ************************************************************
    // Registered so every contact changes on the same edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            relayA <= RELAY_RESET;
            relayB <= RELAY_RESET;
            relayC <= RELAY_RESET;
            relayD <= RELAY_RESET;
            relayF <= RELAY_RESET;
        end else if (clkEn) begin
            relayA <= relayAD;
            relayB <= relayBD;
            relayC <= relayCD;
            relayD <= relayDD;
            relayF <= relayFD;
        end
    end

    // Changeover: normal side closed at rest
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startTwoNormal <= 1'b1;
            startTwoActive <= 1'b0;
        end else if (clkEn) begin
            startTwoNormal <= ~relayFD;
            startTwoActive <= relayFD;
        end
    end

    // ************************************************************
    // Self-supervision
    // ************************************************************
    // Fail-safe: coil drops in reset and on any fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarmCoil           <= COIL_RESET;
            alarmHealthyContact <= COIL_RESET;
            alarmFaultContact   <= ~COIL_RESET;
        end else if (clkEn) begin
            alarmCoil           <= ~internalFault;
            alarmHealthyContact <= ~internalFault;
            alarmFaultContact   <= internalFault;
        end
    end

    // ************************************************************
    // Stage status
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowStart  <= RELAY_RESET;
            lowTrip   <= RELAY_RESET;
            highStart <= RELAY_RESET;
            highTrip  <= RELAY_RESET;
        end else if (clkEn) begin
            lowStart  <= lsStart;
            lowTrip   <= lsTrip;
            highStart <= hsStart;
            highTrip  <= hsTrip;
        end
    end

endmodule : orrm_matrix
`default_nettype wire

// ### hw/orrm_pkg.sv
// Constants for the output relay routing matrix
// What this block does
// - Relay F always follows the low-set stage start signal.
// - Relay A always follows the low-set stage trip signal.
// - Relay B always follows the high-set stage trip signal.
// - Switch 1 set lets the external block input reach the stages.
// - Relay D ORs high start, low start, high trip via switches 2-4.
// - Relay C ORs high trip (switch 5) and low trip (switch 7).
// - Switch 6 adds high trip to A; switch 8 adds low trip to B.
// - Signalling output (relay C) activates on high trip with switch 5 set, low trip with switch 7 set.
// - First start output (relay D) activates on high trip or either stage start only as routed by switches 2-4.
// - Second start changeover leaves rest position while low stage starts.
// - Alarm coil held energized while healthy; fault or power loss alarms.
// - Stage starts above threshold, trips when its delay then expires.
package orrm_pkg;

    // ************************************************************
    // Switch positions, bit 0 is switch 1
    // ************************************************************
    localparam int SW_COUNT       = 8;
    localparam int SW_BLOCK_ROUTE = 0;
    localparam int SW_HS_START_D  = 1;
    localparam int SW_LS_START_D  = 2;
    localparam int SW_HS_TRIP_D   = 3;
    localparam int SW_HS_TRIP_C   = 4;
    localparam int SW_HS_TRIP_A   = 5;
    localparam int SW_LS_TRIP_C   = 6;
    localparam int SW_LS_TRIP_B   = 7;
    localparam logic [SW_COUNT-1:0] SW_FACTORY = 8'hFF;

    // ************************************************************
    // Stage indices and sizes
    // ************************************************************
    localparam int STAGE_COUNT = 2;
    localparam int STAGE_LOW   = 0;
    localparam int STAGE_HIGH  = 1;
    localparam int CUR_WIDTH   = 16;
    localparam int DLY_WIDTH   = 24;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic RELAY_RESET = 1'b0;
    localparam logic COIL_RESET  = 1'b0;

    typedef enum logic [1:0] {
        ORRM_IDLE    = 2'b00,
        ORRM_STARTED = 2'b01,
        ORRM_TRIPPED = 2'b10
    } orrm_stage_t;

endpackage : orrm_pkg

// ### hw/orrm_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module orrm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("orrm_sync: WIDTH must be at least 1");
        end
    endgenerate

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else if (clkEn) begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule : orrm_sync
`default_nettype wire

// ### sim/orrm_matrix_properties.sv
// Checker for the output relay routing matrix, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module orrm_matrix_properties
    import orrm_pkg::*;
(
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire logic [orrm_pkg::SW_COUNT-1:0] outputRoutingSwitches,
    input wire logic                          internalFault,
    input wire logic                          relayA,
    input wire logic                          relayB,
    input wire logic                          relayC,
    input wire logic                          relayD,
    input wire logic                          relayF,
    input wire logic                          startTwoNormal,
    input wire logic                          startTwoActive,
    input wire logic                          alarmCoil,
    input wire logic                          alarmHealthyContact,
    input wire logic                          alarmFaultContact,
    input wire logic                          lowStart,
    input wire logic                          lowTrip,
    input wire logic                          highStart,
    input wire logic                          highTrip,
    input wire logic                          blockActive
);
    // ************************************************************
    // Routing relations, relays and stage status share one latency
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_relay_f_start: assert property (
        relayF == lowStart) else $error("relay F not following low start");
    chk_relay_a_map: assert property (
        relayA == (lowTrip | ($past(outputRoutingSwitches[SW_HS_TRIP_A])
        & highTrip))) else $error("relay A routing wrong");
    chk_relay_b_map: assert property (
        relayB == (highTrip | ($past(outputRoutingSwitches[SW_LS_TRIP_B])
        & lowTrip))) else $error("relay B routing wrong");
    chk_relay_c_map: assert property (
        relayC == (($past(outputRoutingSwitches[SW_HS_TRIP_C]) & highTrip)
        | ($past(outputRoutingSwitches[SW_LS_TRIP_C]) & lowTrip)))
        else $error("relay C routing wrong");
    chk_relay_d_map: assert property (
        relayD == (($past(outputRoutingSwitches[SW_HS_START_D]) & highStart)
        | ($past(outputRoutingSwitches[SW_LS_START_D]) & lowStart)
        | ($past(outputRoutingSwitches[SW_HS_TRIP_D]) & highTrip)))
        else $error("relay D routing wrong");
    chk_start_two_swap: assert property (
        startTwoActive == relayF && startTwoNormal == !relayF)
        else $error("start changeover contact wrong");
    chk_alarm_coil_health: assert property (
        $past(rst_n) |-> alarmCoil == !$past(internalFault)
        && alarmHealthyContact == alarmCoil && alarmFaultContact == !alarmCoil)
        else $error("alarm output not tracking fault");
    chk_block_route_gate: assert property (
        !$past(outputRoutingSwitches[SW_BLOCK_ROUTE]) |-> !blockActive)
        else $error("block active with route switch off");
    chk_trip_after_start: assert property (
        $rose(lowTrip) |-> $past(lowStart) && lowStart)
        else $error("low trip without prior start");
endmodule : orrm_matrix_properties
bind orrm_matrix orrm_matrix_properties u_chk (
    .clk(clk), .rst_n(rst_n), .outputRoutingSwitches(outputRoutingSwitches),
    .internalFault(internalFault), .relayA(relayA), .relayB(relayB),
    .relayC(relayC), .relayD(relayD), .relayF(relayF),
    .startTwoNormal(startTwoNormal), .startTwoActive(startTwoActive),
    .alarmCoil(alarmCoil), .alarmHealthyContact(alarmHealthyContact),
    .alarmFaultContact(alarmFaultContact), .lowStart(lowStart),
    .lowTrip(lowTrip), .highStart(highStart), .highTrip(highTrip),
    .blockActive(blockActive));
`default_nettype wire

// ### sim/orrm_breaker_model.sv
// Circuit breaker opened by a trip relay contact
`timescale 1ns/100ps
`default_nettype none
module orrm_breaker_model #(
    parameter int MECH_CYCLES = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tripCoil,
    output logic      breakerOpen
);
    int count;
    // Latches open; reclosing is outside this bench
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count       <= 0;
            breakerOpen <= 1'b0;
        end else if (tripCoil && !breakerOpen) begin
            count <= count + 1;
            if (count >= MECH_CYCLES - 1) begin
                breakerOpen <= 1'b1;
            end
        end
    end
endmodule : orrm_breaker_model
`default_nettype wire

// ### sim/testbench.sv
// Self-checking testbench for the output relay routing matrix
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import orrm_pkg::*;
    logic clk, rst_n, pin, fault;
    logic [15:0] cur, lowLvl, highLvl;
    logic [7:0]  sw;
    logic rA, rB, rC, rD, rF, twoN, twoA, coil, hc, fc, lS, lT, hS, hT, blk;
    logic brkA, brkB;
    logic en, bHi;
    int err_count = 0;
    int samples_checked = 0;

    orrm_matrix u_dut (.clk(clk), .rst_n(rst_n), .clkEn(en),
        .neutralCurrent(cur), .lowStartLevel(lowLvl), .highStartLevel(highLvl),
        .lowDelayCycles(24'h000002), .highDelayCycles(24'h000003),
        .outputRoutingSwitches(sw), .blockLowEn(1'b1), .blockHighEn(bHi),
        .externalBlockInput(pin), .internalFault(fault), .relayA(rA),
        .relayB(rB), .relayC(rC), .relayD(rD), .relayF(rF),
        .startTwoNormal(twoN), .startTwoActive(twoA), .alarmCoil(coil),
        .alarmHealthyContact(hc), .alarmFaultContact(fc), .lowStart(lS),
        .lowTrip(lT), .highStart(hS), .highTrip(hT), .blockActive(blk));
    // One prompt and one slow breaker
    orrm_breaker_model #(.MECH_CYCLES(1)) u_brkA (.clk(clk), .rst_n(rst_n),
        .tripCoil(rA), .breakerOpen(brkA));
    orrm_breaker_model #(.MECH_CYCLES(6)) u_brkB (.clk(clk), .rst_n(rst_n),
        .tripCoil(rB), .breakerOpen(brkB));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string name, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    task automatic waitE(input int n);
        repeat (n) @(negedge clk);
    endtask : waitE

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // ************************************************************
    // Each switch alone, with one stage held tripped
    // ************************************************************
    task automatic switchTable(input logic hi);
        logic l;
        l = !hi;
        for (int i = 0; i < 8; i++) begin
            sw = 8'h01 << i;
            waitE(2);
            check("relayA", rA, l | (sw[5] & hi));
            check("relayB", rB, hi | (sw[7] & l));
            check("relayC", rC, (sw[4] & hi) | (sw[6] & l));
            check("relayD", rD, hi & (sw[1] | sw[3]) | (sw[2] & l));
            check("relayF", rF, l);
        end
    endtask : switchTable

    initial begin
        #100000;
        err_count++;
        results();
    end

    initial begin
        rst_n = 1'b0; pin = 1'b0; fault = 1'b0; cur = 16'h0000;
        lowLvl = 16'h0064; highLvl = 16'hFFFF; sw = SW_FACTORY;
        en = 1'b1;
        bHi = 1'b0;
        waitE(2);
        check("startTwoNormal", twoN, 1'b1);
        check("alarmFaultContact", fc, 1'b1);
        rst_n = 1'b1;
        waitE(2);
        check("alarmCoil", coil, 1'b1);
        check("alarmHealthyContact", hc, 1'b1);
        // Low stage start, then trip two counts later
        cur = 16'h00C8;
        waitE(2);
        check("relayF", rF, 1'b1);
        check("startTwoActive", twoA, 1'b1);
        check("startTwoNormal", twoN, 1'b0);
        check("relayD", rD, 1'b1);
        waitE(1);
        check("relayA", rA, 1'b0);
        waitE(1);
        check("relayA", rA, 1'b1);
        check("relayC", rC, 1'b1);
        check("relayB", rB, 1'b1);
        check("lowTrip", lT, 1'b1);
        switchTable(1'b0);
        // Routed block input silences the low stage
        sw = SW_FACTORY;
        pin = 1'b1;
        waitE(5);
        check("blockActive", blk, 1'b1);
        check("lowStart", lS, 1'b0);
        sw = 8'hFE;
        waitE(8);
        check("blockActive", blk, 1'b0);
        check("lowStart", lS, 1'b1);
        pin = 1'b0;
        cur = 16'h0000;
        waitE(3);
        check("relayA", rA, 1'b0);
        check("relayF", rF, 1'b0);
        // High stage alone
        lowLvl = 16'hFFFF;
        highLvl = 16'h0064;
        cur = 16'h00C8;
        sw = 8'h00;
        waitE(10);
        switchTable(1'b1);
        check("breakerA", brkA, 1'b1);
        check("breakerB", brkB, 1'b1);
        check("highStart", hS, 1'b1);
        check("highTrip", hT, 1'b1);
        // Enable low freezes every output, even with current gone
        en = 1'b0;
        cur = 16'h0000;
        waitE(3);
        check("relayB", rB, 1'b1);
        check("highTrip", hT, 1'b1);
        en = 1'b1;
        waitE(2);
        check("relayB", rB, 1'b0);
        check("highTrip", hT, 1'b0);
        // Routed block input silences the high stage when selected
        bHi = 1'b1;
        sw = 8'h01;
        pin = 1'b1;
        cur = 16'h00C8;
        waitE(6);
        check("blockActive", blk, 1'b1);
        check("highStart", hS, 1'b0);
        pin = 1'b0;
        waitE(5);
        check("highStart", hS, 1'b1);
        fault = 1'b1;
        waitE(2);
        check("alarmCoil", coil, 1'b0);
        check("alarmFaultContact", fc, 1'b1);
        fault = 1'b0;
        waitE(2);
        check("alarmHealthyContact", hc, 1'b1);
        results();
    end
endmodule : testbench
`default_nettype wire
